// ### verilog/gfp_egress_client_rate_adapt.sv
// Egress client character rate adapter with signal-fail replacement output.
`timescale 1ns/1ps
module gfp_egress_client_rate_adapt #(
  parameter int DEPTH = gfp_rate_pkg::FIFO_DEPTH,
  parameter int HI = gfp_rate_pkg::FILL_HI,
  parameter int LO = gfp_rate_pkg::FILL_LO,
  parameter int CSF_PERSIST = gfp_rate_pkg::CSF_PERSIST_CYC,
  parameter logic [7:0] IDLE1_D = 8'h11,
  parameter logic [7:0] IDLE2_D = 8'h22,
  parameter logic [7:0] CFG1_D = 8'h33,
  parameter logic [7:0] FC_IDLE_D = 8'h44,
  parameter logic [23:0] FC_NOS_D = 24'h555555,
  parameter logic [7:0] SB_NOS_D = 8'h66
) (
  input wire logic SYS_CLK, // 100 MHz local reference clock.
  input wire logic RST, // Synchronous reset, active high.
  input wire gfp_rate_pkg::mode_t MODE, // Client protocol.
  input wire gfp_rate_pkg::char_t IN_CHAR, // Demapped client character.
  input wire logic IN_VALID, // IN_CHAR is valid.
  output logic IN_READY, // Buffer has room.
  input wire logic CSF_IN, // Far-end client signal fail.
  input wire logic DEFECT_IN, // Local adaptation or transport defect.
  input wire logic FAIL_NOS_SEL, // Send not-operational sequence instead of errors, except in Ethernet mode.
  input wire logic SQUELCH_EN, // Allow muting on persistent fail.
  output gfp_rate_pkg::char_t OUT_CHAR, // Egress character each cycle.
  output logic TX_ENABLE, // Low while the transmitter is silenced.
  input wire logic [9:0] RAW_CODE, // Ingress deserialized word.
  input wire logic LOS_PIN, // Ingress loss of signal, asynchronous.
  input wire logic CLK_LOSS_PIN, // Ingress serializer clock loss, asynchronous.
  output logic [9:0] ALIGNED_CODE, // Ingress word after alignment.
  output logic INGRESS_SYNC, // Ingress alignment held.
  output logic INGRESS_CSF // Ingress client fail indication.
);
  import gfp_rate_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef enum logic [1:0] {ST_RUN, ST_FAIL, ST_MUTE} state_t;

  state_t state_q;
  char_t mem_q [DEPTH];
  char_t rep_q [8];
  logic [AW:0] wr_q, rd_q, fill, hl, pop;
  logic [3:0] rep_len_q, adj_q, run_q, gap_idle_q;
  logic [2:0] pos_q;
  logic [4:0] gap_oct_q;
  logic [31:0] persist_q;
  unit_t last_q, hu, nu, eu;
  logic bnd, head_ok, same, gap_ok, adj_ok, del_ok, ins_ok, uf, fail;
  logic [2:0] los_s_q, clk_s_q;
  logic los_q, clk_loss_q;

  function automatic char_t peek(logic [AW:0] i);
    return mem_q[AW'(rd_q[AW-1:0] + i[AW-1:0])];
  endfunction

  // Sort a unit by its first two characters; folds FC4 into FC.
  function automatic unit_t classify(mode_t m, char_t c0, char_t c1);
    unit_t u;
    u = '0;
    u.len = 4'h1;
    u.need = 4'h1;
    u.err = c0.err;
    u.data = !c0.k && !c0.err;
    if (c0.k && !c0.err && c0.d == COMMA_D) begin
      unique case (m)
        MODE_FC, MODE_FC4: begin
          u.len = FC_OS_LEN;
          u.idle = c1.d == FC_IDLE_D;
          u.del_idle = u.idle;
        end
        MODE_SB: begin
          u.idle = c1.k;
          u.len = u.idle ? 4'h1 : SB_OS_LEN;
          u.del_idle = u.idle;
        end
        MODE_GBE: begin
          u.len = (c1.d == CFG1_D) ? GBE_CFG_LEN : GBE_IDLE_LEN;
          u.idle = c1.d == IDLE1_D || c1.d == IDLE2_D;
          u.del_idle = c1.d == IDLE2_D;
        end
      endcase
      u.need = (u.len < 4'h2) ? 4'h2 : u.len;
      u.oset = !u.idle;
    end
    return u;
  endfunction

  // Repeats of one ordered set needed before a copy may be added or dropped.
  function automatic logic [4:0] run_thr(mode_t m, logic [3:0] len);
    logic [4:0] t;
    t = RUN_NEVER;
    unique case (m)
      MODE_FC, MODE_FC4: t = FC_RUN;
      MODE_SB: t = SB_RUN;
      MODE_GBE: t = (len == GBE_CFG_LEN) ? GBE_CFG_RUN : RUN_NEVER;
    endcase
    return t;
  endfunction

  // Gap guards and per-gap adjustment limits by protocol.
  always_comb begin
    gap_ok = 1'b0;
    adj_ok = 1'b0;
    unique case (MODE)
      MODE_FC, MODE_FC4: begin
        gap_ok = gap_idle_q >= FC_MIN_IDLE;
        adj_ok = adj_q < FC_MAX_ADJ;
      end
      MODE_SB: begin
        gap_ok = gap_idle_q >= SB_MIN_IDLE;
        adj_ok = adj_q < SB_MAX_ADJ;
      end
      MODE_GBE: begin
        gap_ok = gap_idle_q >= GBE_MIN_IDLE && gap_oct_q >= GBE_MIN_GAP_OCT;
        adj_ok = adj_q < GBE_MAX_ADJ;
      end
    endcase
  end

  // Decide at each unit boundary whether to pass, drop or repeat a unit.
  always_comb begin
    fill = wr_q - rd_q;
    bnd = state_q == ST_RUN && {1'b0, pos_q} >= rep_len_q - 4'h1; // A position left over from a fail cannot wedge it.
    hu = classify(MODE, peek('0), peek((AW+1)'(1)));
    hl = (AW+1)'(hu.len);
    nu = classify(MODE, peek(hl), peek(hl + (AW+1)'(1)));
    head_ok = fill >= (AW+1)'(hu.need);
    same = hu.len == rep_len_q;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < hu.len && peek((AW+1)'(i)) != rep_q[i]) same = 1'b0;
    end
    del_ok = bnd && head_ok && fill > (AW+1)'(HI) && fill >= hl + (AW+1)'(nu.need) &&
             ((hu.del_idle && gap_ok && adj_ok) ||
              (same && hu.err && run_q >= ERR_RUN) ||
              (same && hu.oset && {1'b0, run_q} >= run_thr(MODE, hu.len)));
    ins_ok = bnd && !del_ok && fill < (AW+1)'(LO) &&
             ((last_q.del_idle && adj_ok) ||
              (last_q.err && run_q >= ERR_RUN) ||
              (last_q.oset && {1'b0, run_q} >= run_thr(MODE, last_q.len)));
    uf = bnd && !del_ok && !ins_ok && !head_ok;
    eu = del_ok ? nu : hu;
    pop = del_ok ? hl + (AW+1)'(nu.len) : (bnd && !ins_ok && !uf) ? hl : '0;
    fail = CSF_IN || DEFECT_IN;
    IN_READY = fill < (AW+1)'(DEPTH);
  end

  // Elastic buffer; a fail flushes it so stale client data is not replayed.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (IN_VALID && IN_READY) begin
        mem_q[wr_q[AW-1:0]] <= IN_CHAR;
        wr_q <= wr_q + (AW+1)'(1);
      end
      if (state_q != ST_RUN) rd_q <= wr_q;
      else rd_q <= rd_q + pop;
    end
  end

  // Fail supervision: replace the client, and go silent if the fail lasts.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_q <= ST_RUN;
      persist_q <= '0;
      TX_ENABLE <= 1'b0;
    end else begin
      TX_ENABLE <= state_q != ST_MUTE;
      unique case (state_q)
        ST_RUN: begin
          persist_q <= '0;
          if (fail) state_q <= ST_FAIL;
        end
        ST_FAIL: begin
          persist_q <= persist_q + 32'h1;
          if (!fail) state_q <= ST_RUN;
          else if (SQUELCH_EN && persist_q >= 32'(CSF_PERSIST - 1)) state_q <= ST_MUTE;
        end
        ST_MUTE: begin
          if (!fail) state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Output stage; the replay buffer holds the unit now being sent.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      OUT_CHAR <= MUTE_CHAR;
      pos_q <= '0;
      rep_len_q <= 4'h1;
      last_q <= '0;
      for (int i = 0; i < 8; i++) rep_q[i] <= ERR_CHAR;
    end else if (state_q == ST_MUTE) begin
      OUT_CHAR <= MUTE_CHAR;
      pos_q <= '0;
      rep_len_q <= 4'h1;
      last_q <= '0;
    end else if (state_q == ST_FAIL) begin
      // No link recovery is started; the far end just loses sync.
      pos_q <= pos_q + 3'h1;
      rep_len_q <= 4'h1;
      last_q <= '0;
      OUT_CHAR <= ERR_CHAR;
      if (FAIL_NOS_SEL && (MODE == MODE_FC || MODE == MODE_FC4)) begin
        OUT_CHAR <= (pos_q[1:0] == 2'h0) ? char_t'{k: 1'b1, err: 1'b0, d: COMMA_D} :
                    char_t'{k: 1'b0, err: 1'b0, d: FC_NOS_D[8*(3-pos_q[1:0]) +: 8]};
      end else if (FAIL_NOS_SEL && MODE == MODE_SB) begin
        OUT_CHAR <= pos_q[0] ? char_t'{k: 1'b0, err: 1'b0, d: SB_NOS_D} :
                    char_t'{k: 1'b1, err: 1'b0, d: COMMA_D};
      end
    end else if (bnd) begin
      pos_q <= '0;
      if (ins_ok) begin
        OUT_CHAR <= rep_q[0];
      end else if (uf) begin
        // Underflow fills with error characters rather than stalling the line.
        OUT_CHAR <= ERR_CHAR;
        rep_q[0] <= ERR_CHAR;
        rep_len_q <= 4'h1;
        last_q <= '0;
      end else begin
        OUT_CHAR <= peek(del_ok ? hl : '0);
        rep_len_q <= eu.len;
        last_q <= eu;
        for (int i = 0; i < 8; i++) rep_q[i] <= peek((del_ok ? hl : '0) + (AW+1)'(i));
      end
    end else begin
      OUT_CHAR <= rep_q[pos_q + 3'h1];
      pos_q <= pos_q + 3'h1;
    end
  end

  // Run and gap bookkeeping; any adjustment restarts the repeat count.
  always_ff @(posedge SYS_CLK) begin
    if (RST || state_q != ST_RUN) begin
      run_q <= '0;
      adj_q <= '0;
      gap_idle_q <= '0;
      gap_oct_q <= '0;
    end else if (bnd) begin
      if (ins_ok || del_ok || uf) run_q <= '0;
      else if (!same) run_q <= 4'h1;
      else if (run_q != 4'hf) run_q <= run_q + 4'h1;
      if (ins_ok || del_ok) adj_q <= adj_q + 4'h1;
      if (!ins_ok && !uf && eu.data) begin
        adj_q <= '0;
        gap_idle_q <= '0;
        gap_oct_q <= '0;
      end else if (!uf) begin
        // Idles count two octets each on Ethernet toward the gap length.
        if ((ins_ok ? last_q.idle : eu.idle) && gap_idle_q != 4'hf) gap_idle_q <= gap_idle_q + 4'h1;
        if (gap_oct_q < GBE_MIN_IPG_OCT + 5'h4) gap_oct_q <= gap_oct_q + 5'(ins_ok ? last_q.len : eu.len);
      end
    end
  end

  // Ingress pin conditioning: a change counts once stages two and three agree.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      los_s_q <= '0;
      clk_s_q <= '0;
      los_q <= 1'b0;
      clk_loss_q <= 1'b0;
      INGRESS_CSF <= 1'b0;
    end else begin
      los_s_q <= {los_s_q[1:0], LOS_PIN};
      clk_s_q <= {clk_s_q[1:0], CLK_LOSS_PIN};
      if (los_s_q[1] == los_s_q[2]) los_q <= los_s_q[2];
      if (clk_s_q[1] == clk_s_q[2]) clk_loss_q <= clk_s_q[2];
      INGRESS_CSF <= !INGRESS_SYNC || los_q || clk_loss_q;
    end
  end

  // Ingress codeword alignment feeding the fail indication.
  codeword_align #(
    .ACQ(ALIGN_ACQ),
    .LOSS(ALIGN_LOSS)
  ) u_align (
    .clk(SYS_CLK),
    .rst(RST),
    .code_in(RAW_CODE),
    .code_out(ALIGNED_CODE),
    .in_sync(INGRESS_SYNC)
  );
endmodule

// ### include/gfp_rate_pkg.sv
// Shared types and constants for the egress client rate adaptation block.
package gfp_rate_pkg;
  typedef enum logic [1:0] {MODE_FC, MODE_FC4, MODE_SB, MODE_GBE} mode_t;
  typedef struct packed {
    logic k;
    logic err;
    logic [7:0] d;
  } char_t;
  typedef struct packed {
    logic [3:0] len;
    logic [3:0] need;
    logic idle;
    logic del_idle;
    logic oset;
    logic err;
    logic data;
  } unit_t;
  localparam logic [7:0] COMMA_D = 8'hbc;
  localparam char_t ERR_CHAR = '{k: 1'b0, err: 1'b1, d: 8'h00};
  localparam char_t MUTE_CHAR = '{k: 1'b0, err: 1'b0, d: 8'h00};
  localparam logic [3:0] SB_OS_LEN = 4'h2;
  localparam logic [3:0] FC_OS_LEN = 4'h4;
  localparam logic [3:0] GBE_IDLE_LEN = 4'h2;
  localparam logic [3:0] GBE_CFG_LEN = 4'h8;
  localparam logic [3:0] SB_MIN_IDLE = 4'h4;
  localparam logic [3:0] FC_MIN_IDLE = 4'h2;
  localparam logic [3:0] GBE_MIN_IDLE = 4'h1;
  localparam logic [4:0] GBE_MIN_GAP_OCT = 5'h08;
  localparam logic [4:0] GBE_MIN_IPG_OCT = 5'h0c;
  localparam logic [3:0] SB_MAX_ADJ = 4'h2;
  localparam logic [3:0] FC_MAX_ADJ = 4'hf;
  localparam logic [3:0] GBE_MAX_ADJ = 4'h1;
  localparam logic [4:0] SB_RUN = 5'h08;
  localparam logic [4:0] FC_RUN = 5'h03;
  localparam logic [4:0] GBE_CFG_RUN = 5'h03;
  localparam logic [4:0] RUN_NEVER = 5'h10;
  localparam logic [3:0] ERR_RUN = 4'hc;
  localparam int FIFO_DEPTH = 16;
  localparam int FILL_HI = 12;
  localparam int FILL_LO = 6;
  localparam int CLK_MHZ = 100;
  localparam int CSF_PERSIST_US = 1000;
  localparam int CSF_PERSIST_CYC = CSF_PERSIST_US * CLK_MHZ;
  localparam int ALIGN_ACQ = 3;
  localparam int ALIGN_LOSS = 4;
endpackage

// ### verilog/codeword_align.sv
// Comma based 10-bit codeword aligner with a simple sync tracker.
`timescale 1ns/1ps
module codeword_align #(
  parameter int ACQ = 3,
  parameter int LOSS = 4
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [9:0] code_in, // Raw 10-bit word, arbitrary bit phase.
  output logic [9:0] code_out, // Word realigned to the locked phase.
  output logic in_sync // High while alignment is held.
);
  logic [9:0] prev_q;
  logic [3:0] off_q;
  logic [2:0] good_q;
  logic [2:0] bad_q;
  logic [19:0] win;
  logic hit;
  logic [3:0] hit_off;

  // Search every bit phase of the two-word window for a comma.
  always_comb begin
    win = {prev_q, code_in};
    hit = 1'b0;
    hit_off = 4'h0;
    for (int o = 0; o < 10; o++) begin
      if (!hit && (win[o+3 +: 7] == 7'b0011111 || win[o+3 +: 7] == 7'b1100000)) begin
        hit = 1'b1;
        hit_off = 4'(o);
      end
    end
  end

  // A comma at the locked phase confirms; one elsewhere moves the phase before sync and counts against sync once held.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 10'h000;
      off_q <= 4'h0;
      good_q <= 3'h0;
      bad_q <= 3'h0;
      in_sync <= 1'b0;
      code_out <= 10'h000;
    end else begin
      prev_q <= code_in;
      code_out <= win[off_q +: 10];
      if (hit && hit_off == off_q) begin
        bad_q <= 3'h0;
        if (good_q != 3'(ACQ)) good_q <= good_q + 3'h1;
        if (good_q == 3'(ACQ - 1)) in_sync <= 1'b1;
      end else if (hit) begin
        if (!in_sync) begin
          off_q <= hit_off;
          good_q <= 3'h1;
        end else if (bad_q == 3'(LOSS - 1)) begin
          in_sync <= 1'b0;
          good_q <= 3'h0;
          bad_q <= 3'h0;
        end else begin
          bad_q <= bad_q + 3'h1;
        end
      end
    end
  end
endmodule

// ### bench/egress_rx_model.sv
// Downstream client receiver model that counts frame data and idle gaps.
`timescale 1ns/1ps
module egress_rx_model (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire gfp_rate_pkg::char_t rx_char, // Character from the egress side.
  input wire logic rx_en, // Transmitter enabled.
  output int data_cnt, // Data characters seen.
  output int min_gap, // Fewest commas seen ahead of a frame.
  output int max_gap // Most commas seen ahead of a frame.
);
  import gfp_rate_pkg::*;
  int gap_q;
  logic seen_q;
  logic prev_comma_q;
  // A gap is only measured when a comma directly leads the frame, since underflow fill is not idle.
  always_ff @(posedge clk) begin
    if (rst) begin
      data_cnt <= 0;
      min_gap <= 99;
      max_gap <= 0;
      gap_q <= 0;
      seen_q <= 1'b0;
      prev_comma_q <= 1'b0;
    end else if (rx_en) begin
      prev_comma_q <= rx_char.k && rx_char.d == COMMA_D;
      if (rx_char.k && rx_char.d == COMMA_D) begin
        gap_q <= gap_q + 1;
      end else if (!rx_char.k && !rx_char.err && rx_char.d != 8'h00) begin
        data_cnt <= data_cnt + 1;
        gap_q <= 0;
        seen_q <= 1'b1;
        if (seen_q && prev_comma_q && gap_q < min_gap) begin
          min_gap <= gap_q;
        end
        if (seen_q && prev_comma_q && gap_q > max_gap) begin
          max_gap <= gap_q;
        end
      end
    end
  end
endmodule

// ### bench/rate_adapt_properties.sv
// Concurrent checks on the rate adapter's ports.
`timescale 1ns/1ps
module rate_adapt_properties #(
  parameter int CSF_PERSIST = 20
) (
  input wire logic SYS_CLK, // Clock.
  input wire logic RST, // Reset.
  input wire gfp_rate_pkg::mode_t MODE, // Protocol.
  input wire logic IN_READY, // Room flag.
  input wire logic CSF_IN, // Far-end fail.
  input wire logic DEFECT_IN, // Local defect.
  input wire logic FAIL_NOS_SEL, // Sequence select.
  input wire logic SQUELCH_EN, // Mute allow.
  input wire gfp_rate_pkg::char_t OUT_CHAR, // Egress char.
  input wire logic TX_ENABLE, // Transmit on.
  input wire logic LOS_PIN, // Signal loss.
  input wire logic CLK_LOSS_PIN, // Clock loss.
  input wire logic INGRESS_SYNC, // Aligned.
  input wire logic INGRESS_CSF // Ingress fail.
);
  import gfp_rate_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  int fail_cnt_q;
  logic fail;
  assign fail = CSF_IN || DEFECT_IN;
  // Count persistent fail with muting allowed; saturate so it never wraps.
  always_ff @(posedge SYS_CLK) begin
    if (RST || !(fail && SQUELCH_EN)) begin
      fail_cnt_q <= 0;
    end else if (fail_cnt_q < CSF_PERSIST + 8) begin
      fail_cnt_q <= fail_cnt_q + 1;
    end
  end
  a_reset_out_idle: assert property ($fell(RST) |-> OUT_CHAR == MUTE_CHAR && !TX_ENABLE && IN_READY)
    else $error("reset output state wrong");
  a_gbe_fail_err: assert property ((MODE == MODE_GBE && fail && !SQUELCH_EN)[*3] |-> OUT_CHAR == ERR_CHAR)
    else $error("gbe fail output wrong");
  a_fc_fail_err: assert property ((MODE != MODE_GBE && fail && !FAIL_NOS_SEL && !SQUELCH_EN)[*3]
    |-> OUT_CHAR == ERR_CHAR) else $error("fail error char missing");
  a_nos_no_err: assert property ((MODE != MODE_GBE && fail && FAIL_NOS_SEL && !SQUELCH_EN)[*6]
    |-> OUT_CHAR != ERR_CHAR) else $error("sequence replaced by errors");
  a_persist_mute: assert property (fail_cnt_q > CSF_PERSIST + 4 |-> !TX_ENABLE && OUT_CHAR == MUTE_CHAR)
    else $error("persistent fail not muted");
  a_tx_stays_on: assert property ((!SQUELCH_EN && !fail)[*3] |-> TX_ENABLE)
    else $error("transmitter off without mute");
  a_los_csf: assert property (LOS_PIN[*6] |-> INGRESS_CSF)
    else $error("signal loss not flagged");
  a_clkloss_csf: assert property (CLK_LOSS_PIN[*6] |-> INGRESS_CSF)
    else $error("clock loss not flagged");
  a_nosync_csf: assert property (!INGRESS_SYNC[*3] |-> INGRESS_CSF)
    else $error("sync loss not flagged");
  c_gbe_fail: cover property (MODE == MODE_GBE && fail ##3 OUT_CHAR == ERR_CHAR);
  c_mute: cover property ($fell(TX_ENABLE));
  c_sync: cover property ($rose(INGRESS_SYNC));
endmodule

// ### bench/gfp_egress_client_rate_adapt_tb.sv
// Self-checking bench for the egress client rate adapter.
`timescale 1ns/1ps
module gfp_egress_client_rate_adapt_tb;
  import gfp_rate_pkg::*;
  localparam int PERSIST = 20;
  typedef struct {mode_t mode; logic csf; logic dfx; logic nos; int n_err; int n_comma;} row_t;
  logic SYS_CLK, RST, IN_VALID, IN_READY, CSF_IN, DEFECT_IN, FAIL_NOS_SEL, SQUELCH_EN, TX_ENABLE;
  logic LOS_PIN, CLK_LOSS_PIN, INGRESS_SYNC, INGRESS_CSF;
  logic [9:0] RAW_CODE, ALIGNED_CODE;
  mode_t MODE;
  char_t IN_CHAR, OUT_CHAR;
  int err_count, checked, m_data, m_gap, m_gmax, ne, nc, w;
  int cycles = 0;
  row_t rows[6];
  gfp_egress_client_rate_adapt #(.CSF_PERSIST(PERSIST)) uut (.SYS_CLK(SYS_CLK), .RST(RST), .MODE(MODE),
    .IN_CHAR(IN_CHAR), .IN_VALID(IN_VALID), .IN_READY(IN_READY), .CSF_IN(CSF_IN), .DEFECT_IN(DEFECT_IN),
    .FAIL_NOS_SEL(FAIL_NOS_SEL), .SQUELCH_EN(SQUELCH_EN), .OUT_CHAR(OUT_CHAR), .TX_ENABLE(TX_ENABLE),
    .RAW_CODE(RAW_CODE), .LOS_PIN(LOS_PIN), .CLK_LOSS_PIN(CLK_LOSS_PIN), .ALIGNED_CODE(ALIGNED_CODE),
    .INGRESS_SYNC(INGRESS_SYNC), .INGRESS_CSF(INGRESS_CSF));
  egress_rx_model rx (.clk(SYS_CLK), .rst(RST), .rx_char(OUT_CHAR), .rx_en(TX_ENABLE), .data_cnt(m_data),
    .min_gap(m_gap), .max_gap(m_gmax));
  // Free running clock; the cycle counter cuts a hang short.
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reset is held ten cycles; control inputs return to their quiet state.
  task automatic do_reset(input mode_t m);
    RST = 1'b1;
    MODE = m;
    {CSF_IN, DEFECT_IN, FAIL_NOS_SEL, SQUELCH_EN, IN_VALID} = 5'h00;
    repeat (10) @(negedge SYS_CLK);
    RST = 1'b0;
  endtask
  initial begin
    {err_count, checked} = '0;
    IN_CHAR = MUTE_CHAR;
    RAW_CODE = 10'h000;
    {LOS_PIN, CLK_LOSS_PIN} = 2'h0;
    rows = '{'{MODE_GBE, 1, 0, 0, 8, 0}, '{MODE_GBE, 0, 1, 1, 8, 0}, '{MODE_FC, 0, 1, 0, 8, 0},
      '{MODE_FC4, 1, 0, 1, 0, 2}, '{MODE_SB, 1, 0, 0, 8, 0}, '{MODE_SB, 0, 1, 1, 0, 4}};
    // Each row raises a fail and counts replacement characters over eight cycles.
    foreach (rows[i]) begin
      do_reset(rows[i].mode);
      {CSF_IN, DEFECT_IN, FAIL_NOS_SEL} = {rows[i].csf, rows[i].dfx, rows[i].nos};
      repeat (3) @(negedge SYS_CLK);
      {ne, nc} = '0;
      repeat (8) begin
        @(negedge SYS_CLK);
        ne += (OUT_CHAR === ERR_CHAR);
        nc += (OUT_CHAR.k === 1'b1 && OUT_CHAR.d === COMMA_D);
      end
      chk(ne, rows[i].n_err);
      chk(nc, rows[i].n_comma);
      $display("fail row %0d done", i);
    end
    // Reset state and underflow fill.
    RST = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk({OUT_CHAR, TX_ENABLE, IN_READY}, {MUTE_CHAR, 2'b01});
    do_reset(MODE_SB);
    repeat (4) @(negedge SYS_CLK);
    chk(OUT_CHAR, ERR_CHAR);
    $display("reset test done");
    // Persistent fail with muting allowed silences the transmitter.
    CSF_IN = 1'b1;
    SQUELCH_EN = 1'b1;
    repeat (PERSIST + 6) @(negedge SYS_CLK);
    chk({TX_ENABLE, OUT_CHAR}, {1'b0, MUTE_CHAR});
    $display("mute test done");
    // Three frames of four data chars, each behind six idles, in serial channel mode.
    do_reset(MODE_SB);
    for (int f = 0; f < 3; f++) begin
      for (int i = 0; i < 10; i++) begin
        IN_VALID = 1'b1;
        IN_CHAR = (i < 6) ? char_t'({2'b10, COMMA_D}) : char_t'({2'b00, 8'(f * 4 + i - 5)});
        @(negedge SYS_CLK);
      end
    end
    IN_CHAR = char_t'({2'b10, COMMA_D});
    repeat (8) @(negedge SYS_CLK);
    IN_VALID = 1'b0;
    repeat (30) @(negedge SYS_CLK);
    chk(m_data, 12);
    chk(m_gap >= 4, 1);
    chk(m_gmax <= 8, 1);
    $display("frame test done");
    // Ingress alignment on a steady comma word, then signal loss.
    RAW_CODE = 10'b0011111010;
    w = 0;
    while (INGRESS_SYNC !== 1'b1 && w < 40) begin
      @(negedge SYS_CLK);
      w++;
    end
    repeat (3) @(negedge SYS_CLK);
    chk({INGRESS_SYNC, INGRESS_CSF}, 2'b10);
    chk(ALIGNED_CODE, 10'b0011111010);
    LOS_PIN = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    chk(INGRESS_CSF, 1);
    LOS_PIN = 1'b0;
    repeat (6) @(negedge SYS_CLK);
    CLK_LOSS_PIN = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    chk(INGRESS_CSF, 1);
    $display("ingress test done");
    final_report();
  end
endmodule
bind gfp_egress_client_rate_adapt rate_adapt_properties #(.CSF_PERSIST(CSF_PERSIST)) props (.SYS_CLK(SYS_CLK),
  .RST(RST), .MODE(MODE), .IN_READY(IN_READY), .CSF_IN(CSF_IN), .DEFECT_IN(DEFECT_IN),
  .FAIL_NOS_SEL(FAIL_NOS_SEL), .SQUELCH_EN(SQUELCH_EN), .OUT_CHAR(OUT_CHAR), .TX_ENABLE(TX_ENABLE),
  .LOS_PIN(LOS_PIN), .CLK_LOSS_PIN(CLK_LOSS_PIN), .INGRESS_SYNC(INGRESS_SYNC), .INGRESS_CSF(INGRESS_CSF));
